// ### src/flh_pkg.sv
// Package of constants and types for the fault latch and history block
`default_nettype none
package flh_pkg;

    localparam int NUM_CODES      = 15;
    localparam int CODE_W         = 4;
    localparam int HIST_DEPTH     = 16;
    localparam int HIST_IDX_W     = 4;
    localparam int STAMP_W        = 32;
    localparam int CLK_FREQ_HZ    = 100_000_000;
    localparam int SECOND_S       = 1;
    localparam int CYCLES_PER_SEC = CLK_FREQ_HZ * SECOND_S;

    // Fault codes
    localparam logic [3:0] CODE_THERMAL_TRIP  = 4'h0;
    localparam logic [3:0] CODE_PHASE_LOSS    = 4'h1;
    localparam logic [3:0] CODE_IMBALANCE     = 4'h2;
    localparam logic [3:0] CODE_LOCKED_ROTOR  = 4'h3;
    localparam logic [3:0] CODE_THERMAL_WARN  = 4'h4;
    localparam logic [3:0] CODE_THERMISTOR_OT = 4'h5;
    localparam logic [3:0] CODE_THERMISTOR_WR = 4'h6;
    localparam logic [3:0] CODE_CHECKBACK     = 4'h7;
    localparam logic [3:0] CODE_LOW_I_TRIP    = 4'h8;
    localparam logic [3:0] CODE_LOW_I_WARN    = 4'h9;
    localparam logic [3:0] CODE_HIGH_I_TRIP   = 4'hA;
    localparam logic [3:0] CODE_HIGH_I_WARN   = 4'hB;
    localparam logic [3:0] CODE_EARTH_TRIP    = 4'hC;
    localparam logic [3:0] CODE_EARTH_WARN    = 4'hD;
    localparam logic [3:0] CODE_SELFTEST      = 4'hE;

    // Codes that are protection trips (eligible for automatic acknowledge)
    localparam logic [14:0] PROT_MASK = 15'h052F;

    localparam logic [14:0] LATCH_RST = 15'h0000;
    localparam logic [4:0]  COUNT_RST = 5'h00;

    typedef struct packed {
        logic [STAMP_W-1:0] stamp;
        logic [CODE_W-1:0]  code;
    } flh_entry_t;

    typedef struct packed {
        logic               valid;
        logic [CODE_W-1:0]  code;
        logic [STAMP_W-1:0] stamp;
    } flh_diag_t;

    typedef struct packed {
        logic panel;
        logic fieldbus;
        logic [2:0] mfIn;
    } flh_ack_t;

endpackage
`default_nettype wire

// ### src/flh_sec_timer.sv
// Seconds-since-power-on counter driven by a one-second enable divider
`timescale 1ns/1ps
`default_nettype none
module flh_sec_timer
#(
    parameter int unsigned CYCLES_PER_SEC = flh_pkg::CYCLES_PER_SEC
)
(
    input  wire logic                        ref_clk,
    input  wire logic                        rstn,
    output logic [flh_pkg::STAMP_W-1:0]      seconds
);

    initial
    begin
        if (CYCLES_PER_SEC < 1)
            $error("CYCLES_PER_SEC must be at least one");
    end

    logic [31:0] divCnt_q;
    logic        tick;

    assign tick = (divCnt_q == 32'(CYCLES_PER_SEC - 1));

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            divCnt_q <= 32'h0000_0000;
        else if (tick)
            divCnt_q <= 32'h0000_0000;
        else
            divCnt_q <= divCnt_q + 32'h0000_0001;
    end

    // Starts at zero on power-up
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            seconds <= '0;
        else if (tick)
            seconds <= seconds + 1'b1;
    end

endmodule
`default_nettype wire

// ### src/flh_history.sv
// Sixteen-entry circular fault history with timestamps
`timescale 1ns/1ps
`default_nettype none
module flh_history
#(
    parameter int DEPTH = flh_pkg::HIST_DEPTH
)
(
    input  wire logic                        ref_clk,
    input  wire logic                        rstn,
    input  wire logic                        wrEn,
    input  wire flh_pkg::flh_entry_t         wrEntry,
    input  wire logic [flh_pkg::HIST_IDX_W-1:0] rdAge,
    output flh_pkg::flh_entry_t              rdEntry,
    output logic                             rdValid,
    output logic [flh_pkg::HIST_IDX_W:0]     count
);

    initial
    begin
        if (DEPTH != (1 << flh_pkg::HIST_IDX_W))
            $error("DEPTH must equal two to the index width");
    end

    flh_pkg::flh_entry_t                mem [DEPTH];
    logic [flh_pkg::HIST_IDX_W-1:0]     wrPtr_q;
    logic [flh_pkg::HIST_IDX_W-1:0]     rdIdx;

    // Write pointer wraps, so the oldest entry is overwritten when full
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            wrPtr_q <= '0;
        else if (wrEn)
            wrPtr_q <= wrPtr_q + 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (wrEn)
            mem[wrPtr_q] <= wrEntry;
    end

    // Empty after power-up: count gates every read
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            count <= flh_pkg::COUNT_RST;
        else if (wrEn && count != 5'(DEPTH))
            count <= count + 1'b1;
    end

    // Age 0 is the newest entry
    assign rdIdx = wrPtr_q - 1'b1 - rdAge;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdEntry <= '0;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= ({1'b0, rdAge} < count);
            rdEntry <= ({1'b0, rdAge} < count) ? mem[rdIdx] : '0;
        end
    end

endmodule
`default_nettype wire

// ### src/flh_fault_latch.sv
// Top of the fault latch, acknowledge, history and indication block
//
// What this block does
// - Detected fault conditions are captured into latched bits.
// - A latched fault stays until an acknowledge clears it.
// - Auto-acknowledge off by default; protection trips then need a user acknowledge.
// - Acknowledge accepted from panel, fieldbus, or enabled multifunction inputs.
// - With auto-acknowledge on, a trip clears once its condition is gone, except earth fault trip (code 12).
// - History keeps the newest 16 recorded faults, one per cycle (lowest new code), with seconds-since-power-on stamps.
// - History is volatile and empty after every power-up.
// - Configuration selects whether relay and DC outputs show summary fault.
// - Red indicator lights on a latched fault until acknowledged.
// - Fieldbus fault flag is one while any fault is latched.
// - The lowest-coded new fault of a cycle issues a diagnosis message when the fieldbus supports it.
// - Thermal overload trip is code 0.
// - Phase loss is code 1.
// - Phase imbalance is code 2.
// - Locked rotor is code 3.
// - Thermal model warning level is code 4.
// - Motor thermistor overtemperature is code 5.
// - Codes 6 and 7 are summaries raised alongside detailed causes.
// - Low current trip is code 8, low current warning code 9.
// - High current trip is code 10, high current warning code 11.
// - Earth fault trip is code 12, earth fault warning code 13.
// - Self-test hardware fault is code 14.
`timescale 1ns/1ps
`default_nettype none
module flh_fault_latch
#(
    parameter int unsigned CYCLES_PER_SEC = flh_pkg::CYCLES_PER_SEC
)
(
    input  wire logic                            ref_clk,
    input  wire logic                            rstn,
    // Raw condition inputs, one per cause, from detection logic
    input  wire logic                            thermalTrip,
    input  wire logic                            phaseLoss,
    input  wire logic                            phaseImbalance,
    input  wire logic                            lockedRotor,
    input  wire logic                            thermalWarn,
    input  wire logic                            thermistorOverTemp,
    input  wire logic [1:0]                      thermistorWiringDetail,
    input  wire logic [2:0]                      checkBackDetail,
    input  wire logic                            lowCurrentTrip,
    input  wire logic                            lowCurrentWarn,
    input  wire logic                            highCurrentTrip,
    input  wire logic                            highCurrentWarn,
    input  wire logic                            earthFaultTrip,
    input  wire logic                            earthFaultWarn,
    input  wire logic                            selfTestFault,
    // Acknowledge sources (asynchronous pins)
    input  wire flh_pkg::flh_ack_t               ackIn,
    // Configuration
    input  wire logic                            autoAckEn,
    input  wire logic [2:0]                      mfAckEn,
    input  wire logic                            relayFaultEn,
    input  wire logic                            dcFaultEn,
    input  wire logic                            diagSupported,
    input  wire logic [flh_pkg::HIST_IDX_W-1:0]  histAge,
    // Indications
    output logic                                 relay_fault_output,
    output logic                                 dc_fault_output,
    output logic                                 redLed,
    output logic                                 busFaultFlag,
    output flh_pkg::flh_diag_t                   diagMsg,
    output logic [flh_pkg::NUM_CODES-1:0]        latched,
    output flh_pkg::flh_entry_t                  histEntry,
    output logic                                 histValid,
    output logic [flh_pkg::HIST_IDX_W:0]         histCount,
    output logic [flh_pkg::STAMP_W-1:0]          uptimeSec
);

    // ------------------------------------------------------------
    // Condition vector
    // ------------------------------------------------------------
    logic [flh_pkg::NUM_CODES-1:0] cond;

    always_comb
    begin
        cond = '0;
        cond[flh_pkg::CODE_THERMAL_TRIP]  = thermalTrip;
        cond[flh_pkg::CODE_PHASE_LOSS]    = phaseLoss;
        cond[flh_pkg::CODE_IMBALANCE]     = phaseImbalance;
        cond[flh_pkg::CODE_LOCKED_ROTOR]  = lockedRotor;
        cond[flh_pkg::CODE_THERMAL_WARN]  = thermalWarn;
        cond[flh_pkg::CODE_THERMISTOR_OT] = thermistorOverTemp;
        // Summaries raised whenever any detail is present
        cond[flh_pkg::CODE_THERMISTOR_WR] = |thermistorWiringDetail;
        cond[flh_pkg::CODE_CHECKBACK]     = |checkBackDetail;
        cond[flh_pkg::CODE_LOW_I_TRIP]    = lowCurrentTrip;
        cond[flh_pkg::CODE_LOW_I_WARN]    = lowCurrentWarn;
        cond[flh_pkg::CODE_HIGH_I_TRIP]   = highCurrentTrip;
        cond[flh_pkg::CODE_HIGH_I_WARN]   = highCurrentWarn;
        cond[flh_pkg::CODE_EARTH_TRIP]    = earthFaultTrip;
        cond[flh_pkg::CODE_EARTH_WARN]    = earthFaultWarn;
        cond[flh_pkg::CODE_SELFTEST]      = selfTestFault;
    end

    // ------------------------------------------------------------
    // Acknowledge synchronisers and edge detect
    // ------------------------------------------------------------
    logic [4:0] ackMeta_q;
    logic [4:0] ackSync_q;
    logic [4:0] ackPrev_q;
    logic [4:0] ackRaw;
    logic       ackPulse;

    assign ackRaw = {ackIn.panel, ackIn.fieldbus, ackIn.mfIn};

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ackMeta_q <= 5'h00;
            ackSync_q <= 5'h00;
            ackPrev_q <= 5'h00;
        end
        else
        begin
            ackMeta_q <= ackRaw;
            ackSync_q <= ackMeta_q;
            ackPrev_q <= ackSync_q;
        end
    end

    // Rising edge only, so a held button does not mask new faults
    assign ackPulse = |(ackSync_q & ~ackPrev_q & {2'b11, mfAckEn});

    // ------------------------------------------------------------
    // Fault latch
    // ------------------------------------------------------------
    logic [flh_pkg::NUM_CODES-1:0] latch_d;
    logic [flh_pkg::NUM_CODES-1:0] newFault;
    logic [flh_pkg::NUM_CODES-1:0] autoClr;

    // Auto clear only applies to protection trips whose condition is gone
    assign autoClr = autoAckEn ? (flh_pkg::PROT_MASK & ~cond) : '0;
    assign newFault = cond & ~latched;

    always_comb
    begin
        latch_d = latched;
        if (ackPulse)
            latch_d = '0;
        latch_d = latch_d & ~autoClr;
        // A live condition wins over any clear in the same cycle
        latch_d = latch_d | cond;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            latched <= flh_pkg::LATCH_RST;
        else
            latched <= latch_d;
    end

    // ------------------------------------------------------------
    // Indications
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            relay_fault_output <= 1'b0;
            dc_fault_output    <= 1'b0;
            redLed             <= 1'b0;
            busFaultFlag       <= 1'b0;
        end
        else
        begin
            relay_fault_output <= relayFaultEn & (|latch_d);
            dc_fault_output    <= dcFaultEn & (|latch_d);
            redLed             <= |latch_d;
            busFaultFlag       <= |latch_d;
        end
    end

    // ------------------------------------------------------------
    // New-fault code selection, lowest code first
    // ------------------------------------------------------------
    logic                         anyNew;
    logic [flh_pkg::CODE_W-1:0]   newCode;

    always_comb
    begin
        anyNew  = |newFault;
        newCode = '0;
        for (int i = flh_pkg::NUM_CODES - 1; i >= 0; i--)
        begin
            if (newFault[i])
                newCode = 4'(i);
        end
    end

    // Several simultaneous new faults: only the lowest code is recorded
    // that cycle; the others are still latched and shown on the outputs.
    logic [flh_pkg::STAMP_W-1:0] seconds;
    flh_pkg::flh_entry_t         wrEntry;

    assign wrEntry.stamp = seconds;
    assign wrEntry.code  = newCode;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            diagMsg <= '0;
        else
        begin
            diagMsg.valid <= anyNew & diagSupported;
            diagMsg.code  <= newCode;
            diagMsg.stamp <= seconds;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            uptimeSec <= '0;
        else
            uptimeSec <= seconds;
    end

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    flh_sec_timer
    #(
        .CYCLES_PER_SEC (CYCLES_PER_SEC)
    )
    uTimer
    (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .seconds (seconds)
    );

    flh_history uHist
    (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .wrEn    (anyNew),
        .wrEntry (wrEntry),
        .rdAge   (histAge),
        .rdEntry (histEntry),
        .rdValid (histValid),
        .count   (histCount)
    );

endmodule
`default_nettype wire

// ### tb/flh_ack_source.sv
// Model of the panel, fieldbus and input sources raising acknowledges
`timescale 1ns/1ps
`default_nettype none
module flh_ack_source
(
    input  wire logic              ref_clk,
    input  wire flh_pkg::flh_ack_t press,
    output var flh_pkg::flh_ack_t  ackIn
);
    // --------------------
    // Held acknowledge
    // --------------------
    // Held four cycles so the two-stage input sync cannot miss it
    logic [2:0] holdCnt [5] = '{default: 3'h0};
    always @(posedge ref_clk)
    begin
        for (int i = 0; i < 5; i++)
            holdCnt[i] <= press[i] ? 3'h4 : holdCnt[i] - {2'h0, |holdCnt[i]};
    end
    always_comb
    begin
        for (int i = 0; i < 5; i++)
            ackIn[i] = |holdCnt[i];
    end
endmodule
`default_nettype wire

// ### tb/flh_fault_latch_checker.sv
// Assertions on the fault latch block's ports
`timescale 1ns/1ps
`default_nettype none
module flh_fault_latch_checker
(
    input wire logic                          ref_clk,
    input wire logic                          rstn,
    input wire logic                          thermalTrip,
    input wire flh_pkg::flh_ack_t             ackIn,
    input wire logic                          autoAckEn,
    input wire logic [2:0]                    mfAckEn,
    input wire logic                          relayFaultEn,
    input wire logic                          dcFaultEn,
    input wire logic                          diagSupported,
    input wire logic                          relay_fault_output,
    input wire logic                          dc_fault_output,
    input wire logic                          redLed,
    input wire logic                          busFaultFlag,
    input wire flh_pkg::flh_diag_t            diagMsg,
    input wire logic [flh_pkg::NUM_CODES-1:0] latched,
    input wire logic [flh_pkg::HIST_IDX_W:0]  histCount,
    input wire logic [flh_pkg::STAMP_W-1:0]   uptimeSec
);
    // --------------------
    // Properties
    // --------------------
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    // Disabled input bits must not count as an acknowledge
    wire ackAny = ackIn.panel | ackIn.fieldbus | (|(ackIn.mfIn & mfAckEn));

    bus_flag_a: assert property (busFaultFlag == (|latched))
        else $error("fieldbus fault flag wrong");
    red_led_a: assert property (redLed == (|latched))
        else $error("red indicator wrong");
    relay_out_a: assert property (relay_fault_output == ($past(relayFaultEn) && |latched))
        else $error("relay output wrong");
    dc_out_a: assert property (dc_fault_output == ($past(dcFaultEn) && |latched))
        else $error("dc output wrong");
    trip_capture_a: assert property (thermalTrip |=> latched[0])
        else $error("trip not latched");
    warn_hold_a: assert property ($fell(latched[4]) |-> $past(ackAny, 3))
        else $error("warning cleared without acknowledge");
    manual_trip_a: assert property (!$past(autoAckEn) && $fell(latched[0]) |-> $past(ackAny, 3))
        else $error("trip cleared without acknowledge");
    auto_clear_a: assert property (autoAckEn && latched[0] && !thermalTrip |=> !latched[0])
        else $error("trip not cleared automatically");
    diag_code_a: assert property (diagMsg.valid |-> $past(diagSupported) && latched[diagMsg.code])
        else $error("diagnosis without latched cause");
    power_up_a: assert property (!$past(rstn) |-> histCount == 5'h00 && uptimeSec == 32'h0)
        else $error("history or uptime not empty after reset");
    uptime_step_a: assert property ($changed(uptimeSec) |-> uptimeSec == $past(uptimeSec) + 32'h1)
        else $error("uptime skipped");
endmodule
bind flh_fault_latch flh_fault_latch_checker flh_fault_latch_checker_inst (.ref_clk, .rstn,
    .thermalTrip, .ackIn, .autoAckEn, .mfAckEn, .relayFaultEn, .dcFaultEn, .diagSupported,
    .relay_fault_output, .dc_fault_output, .redLed, .busFaultFlag, .diagMsg, .latched,
    .histCount, .uptimeSec);
`default_nettype wire

// ### tb/tb_flh_fault_latch.sv
// Self-checking bench for the fault latch and history block
`timescale 1ns/1ps
`default_nettype none
module tb_flh_fault_latch;
    logic                ref_clk, rstn, autoAckEn, relayFaultEn;
    logic                dcFaultEn, diagSupported, histValid;
    logic                relay_fault_output, dc_fault_output, redLed;
    logic                busFaultFlag;
    logic [14:0]         cond, latched;
    logic [2:0]          mfAckEn;
    logic [3:0]          histAge;
    logic [4:0]          histCount;
    logic [31:0]         uptimeSec;
    flh_pkg::flh_ack_t   press, ackIn;
    flh_pkg::flh_diag_t  diagMsg;
    flh_pkg::flh_entry_t histEntry;
    int                  mismatches = 0;
    int                  cmp_count = 0;
    // Condition bits in the upper part, expected code in the low digit
    logic [19:0] rows [16] = '{20'h00010, 20'h00021, 20'h00042, 20'h00083,
        20'h00104, 20'h00205, 20'h00406, 20'h00807, 20'h01008, 20'h02009,
        20'h0400A, 20'h0800B, 20'h1000C, 20'h2000D, 20'h4000E, 20'h000C2};

    flh_fault_latch #(.CYCLES_PER_SEC(10)) flh_fault_latch_inst (.ref_clk, .rstn,
        .thermalTrip(cond[0]), .phaseLoss(cond[1]), .phaseImbalance(cond[2]),
        .lockedRotor(cond[3]), .thermalWarn(cond[4]), .thermistorOverTemp(cond[5]),
        .thermistorWiringDetail({cond[6], 1'b0}), .checkBackDetail({cond[7], 2'h0}),
        .lowCurrentTrip(cond[8]), .lowCurrentWarn(cond[9]), .highCurrentTrip(cond[10]),
        .highCurrentWarn(cond[11]), .earthFaultTrip(cond[12]), .earthFaultWarn(cond[13]),
        .selfTestFault(cond[14]), .ackIn, .autoAckEn, .mfAckEn, .relayFaultEn, .dcFaultEn,
        .diagSupported, .histAge, .relay_fault_output, .dc_fault_output, .redLed,
        .busFaultFlag, .diagMsg, .latched, .histEntry, .histValid, .histCount, .uptimeSec);
    flh_ack_source flh_ack_source_inst (.ref_clk, .press, .ackIn);

    // --------------------
    // Helpers
    // --------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic ack(input logic [4:0] src);
        tick(1);
        press <= src;
        tick(1);
        press <= 5'h00;
        tick(8);
        @(negedge ref_clk);
    endtask
    task automatic test_done();
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // --------------------
    // Stimulus
    // --------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        #50000;
        mismatches++;
        test_done();
    end
    initial
    begin
        {rstn, autoAckEn, dcFaultEn, cond, mfAckEn, histAge, press} = '0;
        {relayFaultEn, diagSupported} = 2'h3;
        tick(2);
        rstn <= 1'b1;
        foreach (rows[i])
        begin
            tick(1);
            cond <= rows[i][18:4];
            tick(1);
            cond <= 15'h0000;
            @(negedge ref_clk);
            chk(latched, rows[i][19:4]);
            chk({diagMsg.valid, diagMsg.code}, {1'b1, rows[i][3:0]});
            chk({busFaultFlag, redLed, relay_fault_output, dc_fault_output}, 4'hE);
            tick(2);
            @(negedge ref_clk);
            chk({histValid, histCount, histEntry.code}, {1'b1, 5'(i + 1), rows[i][3:0]});
            chk(latched, rows[i][19:4]);
            ack(i[0] ? 5'h10 : 5'h08);
            chk({latched, redLed, busFaultFlag}, 17'h0);
        end
        // Full store: the oldest entry gives way and the count stays put
        tick(1);
        cond <= 15'h0020;
        tick(1);
        cond <= 15'h0000;
        histAge <= 4'hF;
        tick(3);
        @(negedge ref_clk);
        chk({histCount, histEntry.code}, {5'h10, 4'h1});
        ack(5'h01);
        chk(latched, 15'h0020);
        tick(1);
        mfAckEn <= 3'h1;
        ack(5'h01);
        chk(latched, 15'h0000);
        tick(1);
        {relayFaultEn, dcFaultEn, diagSupported, autoAckEn} <= 4'h5;
        cond <= 15'h0011;
        // Look in the cycle where a supported diagnosis would pulse
        tick(1);
        @(negedge ref_clk);
        chk({relay_fault_output, dc_fault_output, diagMsg.valid}, 3'h2);
        // Acknowledge while both causes persist: the set side must win
        ack(5'h10);
        chk(latched, 15'h0011);
        tick(1);
        cond <= 15'h0000;
        tick(2);
        @(negedge ref_clk);
        chk(latched, 15'h0010);
        ack(5'h10);
        chk(latched, 15'h0000);
        tick(1);
        rstn <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        @(negedge ref_clk);
        chk({histValid, histCount, latched}, 21'h0);
        chk(uptimeSec, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
